// *** bbr_decode.sv ***
`timescale 1ns/1ps
// Address decoder that classifies an access and derives the bit-band target.
module bbr_decode
   import bbr_pkg::*;
(
   input wire logic [31:0] addr_i,
   output logic is_alias_o,
   output logic is_peri_o,
   output logic [31:0] target_addr_o,
   output logic [2:0] bit_num_o
);
   logic [BBR_ALIAS_BITS-1:0] offset;
   always_comb begin
      // Both alias windows are 32 MB wide and start 32 MB above their region base.
      is_alias_o = (addr_i[31:BBR_ALIAS_BITS] == BBR_SRAM_ALIAS[31:BBR_ALIAS_BITS]) ||
                   (addr_i[31:BBR_ALIAS_BITS] == BBR_PERI_ALIAS[31:BBR_ALIAS_BITS]);
      is_peri_o = (addr_i[31:29] == BBR_PERI_SPACE);
      offset = addr_i[BBR_ALIAS_BITS-1:0];
      // Offset is byte times 32 plus bit times 4, so the byte starts at bit 5.
      bit_num_o = offset[4:2];
      target_addr_o = (is_peri_o ? BBR_PERI_BASE : BBR_SRAM_BASE) |
                      {12'h000, offset[BBR_ALIAS_BITS-1:5]};
   end
endmodule

// *** bbr_mem_model.sv ***
`timescale 1ns/1ps
// Word memory model that answers the remapper's downstream bus.
module bbr_mem_model
   import bbr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic slow_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic lock_i,
   input wire logic [1:0] size_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   output logic ack_o,
   output logic [31:0] rdata_o
);
   logic [31:0] mem [16];
   logic [31:0] last_addr;
   logic [1:0] last_size;
   logic last_lock;
   logic [3:0] last_strb;
   logic [1:0] wait_q;
   int acks;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         wait_q <= 2'h0;
         acks <= 0;
         rdata_o <= 32'h0;
         for (int i = 0; i < 16; i++) mem[i] <= 32'h0;
      end else begin
         ack_o <= 1'b0;
         // Read data outside the answer cycle keeps toggling so stale values never pass.
         rdata_o <= ~rdata_o;
         if (req_i && !ack_o) begin
            if (wait_q != (slow_i ? 2'h3 : 2'h0)) wait_q <= wait_q + 2'h1;
            else begin
               wait_q <= 2'h0;
               ack_o <= 1'b1;
               acks <= acks + 1;
               last_addr <= addr_i;
               last_size <= size_i;
               last_lock <= lock_i;
               last_strb <= wstrb_i;
               rdata_o <= mem[addr_i[5:2]];
               for (int i = 0; i < 4; i++) begin
                  if (we_i && wstrb_i[i]) mem[addr_i[5:2]][8*i+:8] <= wdata_i[8*i+:8];
               end
            end
         end
      end
   end
endmodule

// *** bbr_pkg.sv ***
// Package with address map, size codes and states of the bit-band remapper.
package bbr_pkg;
   localparam logic [31:0] BBR_SRAM_BASE = 32'h2000_0000;
   localparam logic [31:0] BBR_SRAM_ALIAS = 32'h2200_0000;
   localparam logic [31:0] BBR_PERI_BASE = 32'h4000_0000;
   localparam logic [31:0] BBR_PERI_ALIAS = 32'h4200_0000;
   localparam int BBR_REGION_BITS = 20;
   localparam int BBR_ALIAS_BITS = 25;
   localparam logic [6:0] BBR_REGION_TAG_SRAM = 7'h20;
   localparam logic [6:0] BBR_REGION_TAG_PERI = 7'h40;
   localparam logic [2:0] BBR_PERI_SPACE = 3'h2;
   localparam logic [1:0] BBR_SIZE_BYTE = 2'h0;
   localparam logic [1:0] BBR_SIZE_HALF = 2'h1;
   localparam logic [1:0] BBR_SIZE_WORD = 2'h2;
   localparam logic [31:0] BBR_READ_CLEAR = 32'h0000_0000;
   localparam logic [31:0] BBR_READ_SET = 32'h0000_0001;
   typedef enum logic [2:0] {
      BBR_IDLE = 3'b000,
      BBR_PASS = 3'b001,
      BBR_ARD = 3'b010,
      BBR_AWR = 3'b011,
      BBR_DONE = 3'b100
   } bbr_state_t;
endpackage

// *** bbr_remap.sv ***
`timescale 1ns/1ps
// Bit-band remapper between the processor data bus and downstream memory.
module bbr_remap
   import bbr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic req_i,
   input wire logic fetch_i,
   input wire logic we_i,
   input wire logic [1:0] size_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   output logic busy_o,
   output logic done_o,
   output logic err_o,
   output logic [31:0] rdata_o,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic mem_lock_o,
   output logic [1:0] mem_size_o,
   output logic [31:0] mem_addr_o,
   output logic [31:0] mem_wdata_o,
   output logic [3:0] mem_wstrb_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i
);
   bbr_state_t state_q;
   logic is_alias, is_peri;
   logic [31:0] target;
   logic [2:0] bit_num;
   logic [4:0] bit_pos_q;
   logic wbit_q;

   bbr_decode u_dec (
      .addr_i(addr_i),
      .is_alias_o(is_alias),
      .is_peri_o(is_peri),
      .target_addr_o(target),
      .bit_num_o(bit_num)
   );

   // Bit position of the target bit inside the little-endian bus lane.
   function automatic logic [4:0] lane_bit(input logic [1:0] a, input logic [2:0] b);
      return {a, b};
   endfunction

   function automatic logic [3:0] size_strb(input logic [1:0] s, input logic [1:0] a);
      unique case (s)
         BBR_SIZE_BYTE: return 4'h1 << a;
         BBR_SIZE_HALF: return a[1] ? 4'hc : 4'h3;
         default: return 4'hf;
      endcase
   endfunction

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= BBR_IDLE;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         err_o <= 1'b0;
         rdata_o <= 32'h0000_0000;
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_lock_o <= 1'b0;
         mem_size_o <= BBR_SIZE_BYTE;
         mem_addr_o <= 32'h0000_0000;
         mem_wdata_o <= 32'h0000_0000;
         mem_wstrb_o <= 4'h0;
         bit_pos_q <= 5'h00;
         wbit_q <= 1'b0;
      end else begin
         done_o <= 1'b0;
         err_o <= 1'b0;
         unique case (state_q)
            BBR_IDLE: begin
               if (req_i) begin
                  busy_o <= 1'b1;
                  if (fetch_i && is_peri) begin
                     // Peripheral space is execute-never, alias included.
                     busy_o <= 1'b0;
                     done_o <= 1'b1;
                     err_o <= 1'b1;
                     rdata_o <= 32'h0000_0000;
                  end else if (is_alias && !fetch_i) begin
                     mem_req_o <= 1'b1;
                     mem_we_o <= 1'b0;
                     mem_lock_o <= 1'b1;
                     mem_size_o <= size_i;
                     mem_addr_o <= target;
                     mem_wstrb_o <= 4'h0;
                     bit_pos_q <= lane_bit(target[1:0], bit_num);
                     wbit_q <= wdata_i[0];
                     state_q <= BBR_ARD;
                  end else begin
                     // Direct and fetch accesses go through untouched.
                     mem_req_o <= 1'b1;
                     mem_we_o <= we_i;
                     mem_lock_o <= 1'b0;
                     mem_size_o <= size_i;
                     mem_addr_o <= addr_i;
                     mem_wdata_o <= wdata_i;
                     mem_wstrb_o <= wstrb_i;
                     state_q <= BBR_PASS;
                  end
               end
            end
            BBR_PASS: begin
               if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
                  rdata_o <= mem_rdata_i;
                  state_q <= BBR_IDLE;
               end
            end
            BBR_ARD: begin
               if (mem_ack_i) begin
                  if (mem_we_o == 1'b0 && !we_i) begin
                     mem_req_o <= 1'b0;
                     mem_lock_o <= 1'b0;
                     busy_o <= 1'b0;
                     done_o <= 1'b1;
                     rdata_o <= mem_rdata_i[bit_pos_q] ? BBR_READ_SET : BBR_READ_CLEAR;
                     state_q <= BBR_IDLE;
                  end else begin
                     // Lock stays high so nothing slips between read and write.
                     mem_we_o <= 1'b1;
                     mem_wdata_o <= mem_rdata_i;
                     mem_wdata_o[bit_pos_q] <= wbit_q;
                     mem_wstrb_o <= size_strb(mem_size_o, mem_addr_o[1:0]);
                     state_q <= BBR_AWR;
                  end
               end
            end
            BBR_AWR: begin
               if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  mem_we_o <= 1'b0;
                  mem_lock_o <= 1'b0;
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
                  rdata_o <= 32'h0000_0000;
                  state_q <= BBR_IDLE;
               end
            end
            default: state_q <= BBR_IDLE;
         endcase
      end
   end

   property p_fetch_refused;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_q == BBR_IDLE && req_i && fetch_i && is_peri) |=> (err_o && done_o && !mem_req_o);
   endproperty
   a_fetch_refused: assert property (p_fetch_refused) else $error("peripheral fetch not refused");

   property p_alias_target;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_q == BBR_IDLE && req_i && is_alias && !fetch_i) |=>
         (mem_addr_o == $past(target) && mem_size_o == $past(size_i) && mem_lock_o);
   endproperty
   a_alias_target: assert property (p_alias_target) else $error("alias remap wrong");

   property p_pass_unchanged;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_q == BBR_IDLE && req_i && !is_alias && !is_peri) |=>
         (mem_addr_o == $past(addr_i) && mem_wdata_o == $past(wdata_i) && mem_wstrb_o == $past(wstrb_i));
   endproperty
   a_pass_unchanged: assert property (p_pass_unchanged) else $error("pass access altered");

   property p_read_value;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_q == BBR_ARD && mem_ack_i && !mem_we_o && !we_i) |=> (rdata_o[31:1] == 31'h0);
   endproperty
   a_read_value: assert property (p_read_value) else $error("alias read upper bits set");

   property p_rmw_bit;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_q == BBR_ARD && mem_ack_i && we_i) |=> (mem_wdata_o[bit_pos_q] == wbit_q && mem_we_o);
   endproperty
   a_rmw_bit: assert property (p_rmw_bit) else $error("rmw bit wrong");

   property p_lock_held;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_q == BBR_AWR) |-> (mem_lock_o && mem_req_o);
   endproperty
   a_lock_held: assert property (p_lock_held) else $error("lock dropped in rmw");

   // The write phase must follow the read phase on the same target with no gap in the request.
   property p_rmw_addr;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_q == BBR_ARD && mem_ack_i && we_i) |=>
         (mem_req_o && mem_lock_o && mem_addr_o == $past(mem_addr_o) &&
          mem_size_o == $past(mem_size_o));
   endproperty
   a_rmw_addr: assert property (p_rmw_addr) else $error("rmw target moved");

   property p_bit_range;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_q == BBR_IDLE && req_i && is_alias && !fetch_i) |=> (bit_pos_q[2:0] == $past(addr_i[4:2]));
   endproperty
   a_bit_range: assert property (p_bit_range) else $error("bit number decode wrong");

   property p_sram_fetch;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_q == BBR_IDLE && req_i && fetch_i && !is_peri) |=> (mem_addr_o == $past(addr_i) && !err_o);
   endproperty
   a_sram_fetch: assert property (p_sram_fetch) else $error("fetch remapped");
endmodule

// *** bbr_remap_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench of the bit-band remapper against a word memory model.
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module bbr_remap_tb
   import bbr_pkg::*;
;
   logic ref_clk_i = 0, rst_n_i = 0, req_i = 0, fetch_i = 0, we_i = 0, slow = 0;
   logic [1:0] size_i = 2'h0;
   logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, rd;
   logic [3:0] wstrb_i = 4'h0;
   logic busy_o, done_o, err_o, mem_req_o, mem_we_o, mem_lock_o, mem_ack_i, er;
   logic [1:0] mem_size_o;
   logic [31:0] rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
   logic [3:0] mem_wstrb_o;
   int mismatches = 0, check_count = 0, cycles = 0, a0;
   bbr_remap u_bbr_remap (.ref_clk_i, .rst_n_i, .req_i, .fetch_i, .we_i, .size_i, .addr_i,
      .wdata_i, .wstrb_i, .busy_o, .done_o, .err_o, .rdata_o, .mem_req_o, .mem_we_o,
      .mem_lock_o, .mem_size_o, .mem_addr_o, .mem_wdata_o, .mem_wstrb_o, .mem_ack_i,
      .mem_rdata_i);
   bbr_mem_model u_bbr_mem_model (.ref_clk_i, .rst_n_i, .slow_i(slow), .req_i(mem_req_o),
      .we_i(mem_we_o), .lock_i(mem_lock_o), .size_i(mem_size_o), .addr_i(mem_addr_o),
      .wdata_i(mem_wdata_o), .wstrb_i(mem_wstrb_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   initial begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   task automatic tally_and_finish();
      if (mismatches == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   // Request is taken at the first edge while idle, so it is dropped there.
   // The fields stay put until done, since the alias read phase looks at we_i again.
   task automatic xfer(input logic f, w, input logic [1:0] s, input logic [31:0] a, d);
      int n;
      @(posedge ref_clk_i);
      fetch_i <= f;
      we_i <= w;
      size_i <= s;
      addr_i <= a;
      wdata_i <= d;
      wstrb_i <= 4'hf;
      req_i <= 1'b1;
      @(posedge ref_clk_i);
      req_i <= 1'b0;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk_i);
         if (done_o === 1'b1) break;
         `CHK("busy", 1'b1, busy_o)
      end
      rd = rdata_o;
      er = err_o;
      `CHK("done", 1'b1, done_o)
      `CHK("idle", 1'b0, busy_o)
   endtask
   task automatic t_pass();
      xfer(0, 1, BBR_SIZE_WORD, 32'h2000_0004, 32'h0000_00ff);
      `CHK("pass addr", 32'h2000_0004, u_bbr_mem_model.last_addr)
      xfer(1, 0, BBR_SIZE_WORD, 32'h2200_0040, 32'h0);
      `CHK("fetch addr", 32'h2200_0040, u_bbr_mem_model.last_addr)
   endtask
   task automatic t_alias();
      xfer(0, 1, BBR_SIZE_WORD, 32'h2200_00a8, 32'h0000_000f);
      `CHK("set word", 32'h0000_04ff, u_bbr_mem_model.mem[1])
      `CHK("target", 32'h2000_0005, u_bbr_mem_model.last_addr)
      `CHK("lock", 1'b1, u_bbr_mem_model.last_lock)
      slow <= 1'b1;
      xfer(0, 0, BBR_SIZE_BYTE, 32'h2200_00a8, 32'h0);
      `CHK("read set", BBR_READ_SET, rd)
      `CHK("size", BBR_SIZE_BYTE, u_bbr_mem_model.last_size)
      xfer(0, 1, BBR_SIZE_WORD, 32'h2200_00a8, 32'h0000_000e);
      `CHK("clear word", 32'h0000_00ff, u_bbr_mem_model.mem[1])
      xfer(0, 0, BBR_SIZE_WORD, 32'h2200_00a8, 32'h0);
      `CHK("read clear", BBR_READ_CLEAR, rd)
      slow <= 1'b0;
      xfer(0, 1, BBR_SIZE_WORD, 32'h23ff_fffc, 32'h0000_0001);
      `CHK("top bit", 1'b1, u_bbr_mem_model.mem[15][31])
      `CHK("top addr", 32'h200f_ffff, u_bbr_mem_model.last_addr)
      xfer(0, 1, BBR_SIZE_BYTE, 32'h2200_00a8, 32'h0000_00ff);
      `CHK("byte strobe", 4'h2, u_bbr_mem_model.last_strb)
      xfer(0, 1, BBR_SIZE_HALF, 32'h2200_00e0, 32'h0000_0001);
      `CHK("half strobe", 4'hc, u_bbr_mem_model.last_strb)
      `CHK("half word", 32'h0100_04ff, u_bbr_mem_model.mem[1])
   endtask
   // Reset in the middle of a locked read-modify-write must release the downstream bus.
   task automatic t_reset();
      @(posedge ref_clk_i);
      fetch_i <= 1'b0;
      we_i <= 1'b1;
      size_i <= BBR_SIZE_WORD;
      addr_i <= 32'h2200_0000;
      wdata_i <= 32'h0000_0001;
      req_i <= 1'b1;
      @(posedge ref_clk_i);
      req_i <= 1'b0;
      @(posedge ref_clk_i);
      `CHK("locked", 1'b1, mem_lock_o)
      rst_n_i <= 1'b0;
      @(posedge ref_clk_i);
      `CHK("reset lock", 1'b0, mem_lock_o)
      `CHK("reset req", 1'b0, mem_req_o)
      `CHK("reset busy", 1'b0, busy_o)
      rst_n_i <= 1'b1;
   endtask
   task automatic t_peri();
      a0 = u_bbr_mem_model.acks;
      xfer(1, 0, BBR_SIZE_WORD, 32'h4200_0000, 32'h0);
      `CHK("fetch err", 1'b1, er)
      `CHK("no cycle", a0, u_bbr_mem_model.acks)
      xfer(0, 1, BBR_SIZE_WORD, 32'h4200_0004, 32'h0000_0003);
      `CHK("peri target", 32'h4000_0000, u_bbr_mem_model.last_addr)
      xfer(0, 0, BBR_SIZE_WORD, 32'h4000_0000, 32'h0);
      `CHK("peri direct", 32'h0000_0002, rd)
      `CHK("no err", 1'b0, er)
   endtask
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_pass();
      t_alias();
      t_reset();
      t_peri();
      tally_and_finish();
   end
endmodule
